// [logic/ads_diag_core.sv]
// Converter diagnostic selection and balancing switch check logic
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module ads_diag_core #(
  parameter int NCH = 14,
  parameter int DW = 14
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic diag_active,
  input wire logic diag_slot,
  input wire logic diag_valid,
  input wire logic [DW-1:0] diag_data,
  input wire logic meas_valid,
  input wire logic [3:0] meas_chan,
  input wire logic [DW-1:0] meas_data,
  input wire logic scan_end_in,
  output logic scan_request,
  output logic adc_bipolar,
  output logic adc_in_short,
  output logic adc_in_ground,
  output logic cell_ls_ground,
  output logic ls_in_short,
  output logic chop_disable,
  output logic ref_thermistor,
  output logic adc_neg_supply,
  output logic adc_pos_supply,
  output logic dac_route,
  output logic [9:0] dac_code,
  output logic alternate_mux_path,
  output logic [2:0] oversample_out,
  output logic converter_cal_enable
);
  // ==========================================================
  // Software registers
  logic scan_ordering_reg;
  logic [2:0] scan_config_field_reg;
  logic [2:0] oversample_count_reg;
  logic cal_en_reg;
  logic stuck_en_reg;
  logic [3:0] diag_select_first_reg;
  logic [3:0] diag_select_second_reg;
  logic [15:0] diag_result_first_reg;
  logic [15:0] diag_result_second_reg;
  logic [DW-1:0] thr_short_reg;
  logic [DW-1:0] thr_low_reg;
  logic [DW-1:0] thr_high_reg;
  logic [DW-1:0] cal_offset_reg;
  logic [3:0] top_cell_pos_first_reg;
  logic [3:0] top_cell_pos_second_reg;
  logic [NCH-1:0] switch_alert_bits_reg;
  logic switch_alert_summary_reg;
  logic [NCH-1:0] pending_reg;
  logic scan_complete_flag_reg;
  logic zero_fail_reg;
  logic full_fail_reg;
  ads_pkg::ads_state_t state_reg;
  logic wr_go;
  logic sw_mode;
  logic start_go;
  logic finish;
  logic [3:0] act_sel;
  logic [DW-1:0] diag_cal;
  logic [NCH-1:0] alert_mask;
  logic meas_fail;

  // Bus write strobe: a write lands at the edge where the master sees ack
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign sw_mode = scan_config_field_reg[2];
  assign start_go = wr_go && wb_adr_i == ads_pkg::OFS_SCAN_CTRL &&
                    wb_dat_i[ads_pkg::SC_START] && state_reg == ads_pkg::ST_IDLE;
  // scan ends after the stuck pair when enabled
  assign finish = (state_reg == ads_pkg::ST_SCAN && scan_end_in &&
                   !stuck_en_reg) ||
                  (state_reg == ads_pkg::ST_FULL && diag_valid);
  // switch modes disable all diagnostic selections
  assign act_sel = (sw_mode || !diag_active || state_reg != ads_pkg::ST_SCAN)
                   ? ads_pkg::SEL_NONE
                   : (diag_slot ? diag_select_second_reg
                                : diag_select_first_reg);
  assign diag_cal = cal_en_reg ? DW'(diag_data - cal_offset_reg) : diag_data;

  // ==========================================================
  // Bus slave: one wait state, unmapped reads return zero
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h0;
      if (wb_adr_i == ads_pkg::OFS_SCAN_CTRL)
        wb_dat_o <= 32'({stuck_en_reg, cal_en_reg, oversample_count_reg,
                         scan_config_field_reg, scan_ordering_reg, 1'b0});
      else if (wb_adr_i == ads_pkg::OFS_DIAG_CFG)
        wb_dat_o <= 32'({diag_select_second_reg, diag_select_first_reg});
      else if (wb_adr_i == ads_pkg::OFS_RES_FIRST)
        wb_dat_o <= 32'(diag_result_first_reg);
      else if (wb_adr_i == ads_pkg::OFS_RES_SECOND)
        wb_dat_o <= 32'(diag_result_second_reg);
      else if (wb_adr_i == ads_pkg::OFS_THR_SHORT)
        wb_dat_o <= 32'(thr_short_reg);
      else if (wb_adr_i == ads_pkg::OFS_THR_LOW)
        wb_dat_o <= 32'(thr_low_reg);
      else if (wb_adr_i == ads_pkg::OFS_THR_HIGH)
        wb_dat_o <= 32'(thr_high_reg);
      else if (wb_adr_i == ads_pkg::OFS_ALERT)
        wb_dat_o <= 32'({switch_alert_summary_reg, 2'b00,
                         switch_alert_bits_reg});
      else if (wb_adr_i == ads_pkg::OFS_TOP_CELL)
        wb_dat_o <= 32'({top_cell_pos_second_reg, top_cell_pos_first_reg});
      else if (wb_adr_i == ads_pkg::OFS_STATUS)
        wb_dat_o <= 32'({full_fail_reg, zero_fail_reg,
                         scan_complete_flag_reg, state_reg != ads_pkg::ST_IDLE});
      else if (wb_adr_i == ads_pkg::OFS_CAL_OFS)
        wb_dat_o <= 32'(cal_offset_reg);
    end
  end

  // Configuration writes; only lane 0 matters, whole word taken
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      scan_ordering_reg <= 1'b0;
      scan_config_field_reg <= 3'h0;
      oversample_count_reg <= ads_pkg::OVS_DEFAULT;
      cal_en_reg <= 1'b1;
      stuck_en_reg <= 1'b0;
      diag_select_first_reg <= ads_pkg::SEL_NONE;
      diag_select_second_reg <= ads_pkg::SEL_NONE;
      thr_short_reg <= '0;
      thr_low_reg <= '0;
      thr_high_reg <= '1;
      cal_offset_reg <= '0;
      top_cell_pos_first_reg <= ads_pkg::TOP_CELL_RESET;
      top_cell_pos_second_reg <= ads_pkg::TOP_CELL_RESET;
    end
    else if (wr_go && state_reg == ads_pkg::ST_IDLE)
    begin
      // Settings are frozen while a scan runs so the check stays coherent
      if (wb_adr_i == ads_pkg::OFS_SCAN_CTRL)
      begin
        scan_ordering_reg <= wb_dat_i[ads_pkg::SC_ORDER];
        scan_config_field_reg <= wb_dat_i[ads_pkg::SC_CFG_LO +: 3];
        oversample_count_reg <= wb_dat_i[ads_pkg::SC_OVS_LO +: 3];
        cal_en_reg <= wb_dat_i[ads_pkg::SC_CAL_EN];
        stuck_en_reg <= wb_dat_i[ads_pkg::SC_STUCK_EN];
      end
      else if (wb_adr_i == ads_pkg::OFS_DIAG_CFG)
      begin
        diag_select_first_reg <= wb_dat_i[3:0];
        diag_select_second_reg <= wb_dat_i[7:4];
      end
      else if (wb_adr_i == ads_pkg::OFS_THR_SHORT)
        thr_short_reg <= wb_dat_i[DW-1:0];
      else if (wb_adr_i == ads_pkg::OFS_THR_LOW)
        thr_low_reg <= wb_dat_i[DW-1:0];
      else if (wb_adr_i == ads_pkg::OFS_THR_HIGH)
        thr_high_reg <= wb_dat_i[DW-1:0];
      else if (wb_adr_i == ads_pkg::OFS_CAL_OFS)
        cal_offset_reg <= wb_dat_i[DW-1:0];
      else if (wb_adr_i == ads_pkg::OFS_TOP_CELL)
      begin
        top_cell_pos_first_reg <= wb_dat_i[3:0];
        top_cell_pos_second_reg <= wb_dat_i[7:4];
      end
    end
  end

  // ==========================================================
  // Scan sequencer
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_reg <= ads_pkg::ST_IDLE;
      scan_request <= 1'b0;
      scan_complete_flag_reg <= 1'b0;
      zero_fail_reg <= 1'b0;
      full_fail_reg <= 1'b0;
    end
    else
    begin
      scan_request <= start_go;
      if (finish)
        scan_complete_flag_reg <= 1'b1;
      case (state_reg)
        ads_pkg::ST_IDLE:
          if (start_go)
          begin
            state_reg <= ads_pkg::ST_SCAN;
            scan_complete_flag_reg <= 1'b0;
          end
        ads_pkg::ST_SCAN:
          // stuck pair inserted after the scan
          if (scan_end_in)
            state_reg <= stuck_en_reg ? ads_pkg::ST_ZERO : ads_pkg::ST_IDLE;
        ads_pkg::ST_ZERO:
          if (diag_valid)
          begin
            zero_fail_reg <= diag_data != ads_pkg::ZERO_CODE;
            state_reg <= ads_pkg::ST_FULL;
          end
        default:
          if (diag_valid)
          begin
            full_fail_reg <= diag_data != ads_pkg::FULL_CODE;
            state_reg <= ads_pkg::ST_IDLE;
          end
      endcase
    end
  end

  // ==========================================================
  // Diagnostic results, placed in the upper fourteen bits
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      diag_result_first_reg <= 16'h0;
      diag_result_second_reg <= 16'h0;
    end
    // result in bits 15:2, low bits zero
    else if (diag_valid && state_reg == ads_pkg::ST_SCAN && !sw_mode)
    begin
      if (diag_slot)
        diag_result_second_reg <= {diag_cal, 2'b00};
      else
        diag_result_first_reg <= {diag_cal, 2'b00};
    end
  end

  // ==========================================================
  // Analog path steering, registered so pins never glitch
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      adc_bipolar <= 1'b0;
      adc_in_short <= 1'b0;
      adc_in_ground <= 1'b0;
      cell_ls_ground <= 1'b0;
      ls_in_short <= 1'b0;
      chop_disable <= 1'b0;
      ref_thermistor <= 1'b0;
      adc_neg_supply <= 1'b0;
      adc_pos_supply <= 1'b0;
      dac_route <= 1'b0;
      dac_code <= 10'h0;
    end
    else
    begin
      // offset diagnostic, path set by ordering
      // pyramid shorts converter, ramp grounds shifter
      adc_in_short <= act_sel == ads_pkg::SEL_OFFSET && !scan_ordering_reg;
      cell_ls_ground <= act_sel == ads_pkg::SEL_OFFSET && scan_ordering_reg;
      ls_in_short <= act_sel == ads_pkg::SEL_LSHIFT;
      chop_disable <= act_sel == ads_pkg::SEL_LSHIFT ||
                      (act_sel == ads_pkg::SEL_OFFSET && scan_ordering_reg);
      adc_in_ground <= act_sel == ads_pkg::SEL_THERMISTOR_SUPPLY;
      ref_thermistor <= act_sel == ads_pkg::SEL_THERMISTOR_SUPPLY;
      // negative rail for selector or stuck check
      adc_neg_supply <= act_sel == ads_pkg::SEL_ZERO ||
                        state_reg == ads_pkg::ST_ZERO;
      // positive rail for selector or stuck check
      adc_pos_supply <= act_sel == ads_pkg::SEL_FULL ||
                        state_reg == ads_pkg::ST_FULL;
      dac_route <= act_sel == ads_pkg::SEL_DAC_Q1 ||
                   act_sel == ads_pkg::SEL_DAC_Q3;
      dac_code <= act_sel == ads_pkg::SEL_DAC_Q1 ? ads_pkg::DAC_QUARTER :
                  act_sel == ads_pkg::SEL_DAC_Q3 ? ads_pkg::DAC_THREE_Q :
                  10'h0;
      // Bipolar whenever a near-zero or rail measurement is taken
      adc_bipolar <= act_sel == ads_pkg::SEL_OFFSET ||
                     act_sel == ads_pkg::SEL_THERMISTOR_SUPPLY ||
                     act_sel == ads_pkg::SEL_LSHIFT ||
                     act_sel == ads_pkg::SEL_ZERO ||
                     act_sel == ads_pkg::SEL_FULL ||
                     state_reg == ads_pkg::ST_ZERO ||
                     state_reg == ads_pkg::ST_FULL ||
                     (sw_mode && scan_config_field_reg !=
                      ads_pkg::CFG_SW_SHORT);
    end
  end

  // Switch-mode overrides and settings seen by the acquisition engine
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      alternate_mux_path <= 1'b0;
      oversample_out <= ads_pkg::OVS_DEFAULT;
      converter_cal_enable <= 1'b1;
    end
    else
    begin
      // alternate path and single sample in switch modes
      alternate_mux_path <= sw_mode;
      // host oversampling passed on unless overridden
      oversample_out <= sw_mode ? ads_pkg::OVS_DEFAULT : oversample_count_reg;
      converter_cal_enable <= cal_en_reg;
    end
  end

  // ==========================================================
  // Switch comparisons and alert handling
  always_comb
  begin
    // short mode uses one threshold, others a window
    // thresholds read as preset by the host
    if (scan_config_field_reg == ads_pkg::CFG_SW_SHORT)
      meas_fail = meas_data < thr_short_reg;
    else
      meas_fail = meas_data < thr_low_reg || meas_data > thr_high_reg;
  end

  always_comb
  begin
    // equal top cells mask positions above them
    for (int i = 0; i < NCH; i++)
      alert_mask[i] = !(top_cell_pos_first_reg == top_cell_pos_second_reg &&
                        4'(i) > top_cell_pos_first_reg);
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      pending_reg <= '0;
    else if (start_go)
      pending_reg <= '0;
    else if (meas_valid && sw_mode && state_reg == ads_pkg::ST_SCAN &&
             int'(meas_chan) < NCH && meas_fail)
      pending_reg[meas_chan] <= 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      switch_alert_bits_reg <= '0;
      switch_alert_summary_reg <= 1'b0;
    end
    // load at switch scan done, bits clear at switch request
    else if (finish && sw_mode)
    begin
      switch_alert_bits_reg <= pending_reg & alert_mask;
      // summary follows the OR; set beats a clear
      switch_alert_summary_reg <= |(pending_reg & alert_mask);
    end
    else if (start_go && wb_dat_i[ads_pkg::SC_CFG_LO + 2])
      switch_alert_bits_reg <= '0;
    else if (wr_go && wb_adr_i == ads_pkg::OFS_ALERT &&
             !wb_dat_i[ads_pkg::AL_SUMMARY])
      switch_alert_summary_reg <= 1'b0;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_offset_pyramid: assert property (
    act_sel == ads_pkg::SEL_OFFSET && !scan_ordering_reg
    |=> adc_in_short && adc_bipolar && !chop_disable)
    else $error("pyramid offset path wrong");
  a_offset_ramp: assert property (
    act_sel == ads_pkg::SEL_OFFSET && scan_ordering_reg
    |=> cell_ls_ground && chop_disable && adc_bipolar && !adc_in_short)
    else $error("ramp offset path wrong");
  a_thermistor_supply_path: assert property (
    act_sel == ads_pkg::SEL_THERMISTOR_SUPPLY |=> ref_thermistor && adc_in_ground)
    else $error("thermistor path wrong");
  a_dac_quarter: assert property (
    act_sel == ads_pkg::SEL_DAC_Q1
    |=> dac_route && dac_code == ads_pkg::DAC_QUARTER)
    else $error("quarter dac code wrong");
  a_dac_three: assert property (
    act_sel == ads_pkg::SEL_DAC_Q3
    |=> dac_route && dac_code == ads_pkg::DAC_THREE_Q)
    else $error("three quarter dac code wrong");
  a_stuck_order: assert property (
    state_reg == ads_pkg::ST_SCAN && scan_end_in && stuck_en_reg
    |=> state_reg == ads_pkg::ST_ZERO ##1 adc_neg_supply && adc_bipolar)
    else $error("stuck check not inserted");
  a_alert_clear: assert property (
    start_go && wb_dat_i[4] |=> switch_alert_bits_reg == '0)
    else $error("alerts not cleared at request");
  a_summary_or: assert property (
    finish && sw_mode |=> switch_alert_summary_reg == |switch_alert_bits_reg)
    else $error("summary differs from alerts");
  a_result_low: assert property (
    diag_valid && state_reg == ads_pkg::ST_SCAN && !sw_mode && !diag_slot
    |=> diag_result_first_reg[1:0] == 2'b00 &&
        diag_result_first_reg[15:2] == $past(diag_cal))
    else $error("result misplaced");
  a_switch_path: assert property (
    sw_mode |=> alternate_mux_path)
    else $error("alternate path not selected");

  c_stuck_pass: cover property (state_reg == ads_pkg::ST_FULL && diag_valid);
  c_switch_alert: cover property (finish && sw_mode && |pending_reg);
  c_diag_second: cover property (diag_valid && diag_slot &&
                                 state_reg == ads_pkg::ST_SCAN);
endmodule

// [logic/ads_pkg.sv]
// Constants for the converter diagnostic and switch check block
package ads_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_SCAN_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIAG_CFG = 8'h04;
  localparam logic [7:0] OFS_RES_FIRST = 8'h08;
  localparam logic [7:0] OFS_RES_SECOND = 8'h0c;
  localparam logic [7:0] OFS_THR_SHORT = 8'h10;
  localparam logic [7:0] OFS_THR_LOW = 8'h14;
  localparam logic [7:0] OFS_THR_HIGH = 8'h18;
  localparam logic [7:0] OFS_ALERT = 8'h1c;
  localparam logic [7:0] OFS_TOP_CELL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_CAL_OFS = 8'h28;
  // ==========================================================
  // Field positions
  localparam int SC_START = 0;
  localparam int SC_ORDER = 1;
  localparam int SC_CFG_LO = 2;
  localparam int SC_OVS_LO = 5;
  localparam int SC_CAL_EN = 8;
  localparam int SC_STUCK_EN = 9;
  localparam int AL_SUMMARY = 16;
  localparam int RES_LO = 2;
  // ==========================================================
  // Diagnostic selector codes
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_OFFSET = 4'h6;
  localparam logic [3:0] SEL_THERMISTOR_SUPPLY = 4'h9;
  localparam logic [3:0] SEL_ZERO = 4'ha;
  localparam logic [3:0] SEL_FULL = 4'hb;
  localparam logic [3:0] SEL_LSHIFT = 4'hc;
  localparam logic [3:0] SEL_DAC_Q1 = 4'h8;
  localparam logic [3:0] SEL_DAC_Q3 = 4'h7;
  // ==========================================================
  // Scan configuration codes and fixed values
  localparam logic [2:0] CFG_SW_SHORT = 3'h4;
  localparam logic [2:0] CFG_SW_OPEN = 3'h5;
  localparam logic [2:0] CFG_WIRE_ODD = 3'h6;
  localparam logic [2:0] CFG_WIRE_EVEN = 3'h7;
  localparam logic [9:0] DAC_QUARTER = 10'h100;
  localparam logic [9:0] DAC_THREE_Q = 10'h2ff;
  localparam logic [13:0] ZERO_CODE = 14'h0000;
  localparam logic [13:0] FULL_CODE = 14'h3ffc;
  localparam logic [2:0] OVS_DEFAULT = 3'h0;
  localparam logic [3:0] TOP_CELL_RESET = 4'hd;
  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_ZERO, ST_FULL} ads_state_t;
endpackage

// [verif/ads_acq_model.sv]
// Acquisition engine model that answers the block's scan requests
`timescale 1ns/1ps
module ads_acq_model (
  input wire logic core_clk,
  input wire logic scan_request,
  input wire logic adc_neg_supply,
  input wire logic adc_pos_supply,
  input wire logic hold_diag,
  input wire logic [13:0] diag_value,
  input wire logic [13:0] full_value,
  input wire logic [195:0] cell_volts,
  output logic diag_active,
  output logic diag_slot,
  output logic diag_valid,
  output logic [13:0] diag_data,
  output logic meas_valid,
  output logic [3:0] meas_chan,
  output logic [13:0] meas_data,
  output logic scan_end_in
);
  logic busy = 1'b0;
  logic zdone;
  assign diag_active = busy | hold_diag;
  // Idle data lines flip so a stale value is never mistaken for a result
  task pulse_diag(input logic [13:0] v);
    diag_valid <= 1'b1;
    diag_data <= v;
    @(posedge core_clk);
    diag_valid <= 1'b0;
    diag_data <= ~v;
  endtask
  // =====
  // Scan sequence: one diagnostic result, 14 cells, end, stuck pair
  initial
  begin
    {diag_slot, diag_valid, meas_valid, scan_end_in} = '0;
    {diag_data, meas_chan, meas_data} = '0;
    forever
    begin
      @(posedge core_clk);
      if (scan_request === 1'b1)
      begin
        busy <= 1'b1;
        @(posedge core_clk);
        pulse_diag(diag_value);
        for (int i = 0; i < 14; i++)
        begin
          meas_valid <= 1'b1;
          meas_chan <= 4'(i);
          meas_data <= cell_volts[i*14 +: 14];
          @(posedge core_clk);
        end
        meas_valid <= 1'b0;
        meas_data <= ~meas_data;
        scan_end_in <= 1'b1;
        @(posedge core_clk);
        scan_end_in <= 1'b0;
        // zero then full answer, each given once
        // The negative rail lags by a cycle, so it must not be answered twice
        zdone = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
          @(posedge core_clk);
          if (adc_neg_supply === 1'b1 && !zdone)
          begin
            pulse_diag(14'h0000);
            zdone = 1'b1;
          end
          else if (adc_pos_supply === 1'b1)
          begin
            pulse_diag(full_value);
            i = 8;
          end
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// [verif/testbench.sv]
// Self-checking bench for the converter diagnostic block
`timescale 1ns/1ps
module testbench;
  logic core_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, meas_chan;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic diag_active, diag_slot, diag_valid, meas_valid, scan_end_in;
  logic [13:0] diag_data, meas_data, diag_value, full_value;
  logic scan_request, adc_bipolar, adc_in_short, adc_in_ground;
  logic cell_ls_ground, ls_in_short, chop_disable, ref_thermistor;
  logic adc_neg_supply, adc_pos_supply, dac_route, alternate_mux_path;
  logic converter_cal_enable, hold_diag;
  logic [9:0] dac_code;
  logic [2:0] oversample_out;
  logic [195:0] cell_volts;
  int mismatches = 0;
  int total_checks = 0;
  ads_diag_core ads_diag_core_inst (.core_clk, .srst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .diag_active, .diag_slot, .diag_valid, .diag_data,
    .meas_valid, .meas_chan, .meas_data, .scan_end_in, .scan_request,
    .adc_bipolar, .adc_in_short, .adc_in_ground, .cell_ls_ground,
    .ls_in_short, .chop_disable, .ref_thermistor, .adc_neg_supply,
    .adc_pos_supply, .dac_route, .dac_code, .alternate_mux_path,
    .oversample_out, .converter_cal_enable);
  ads_acq_model ads_acq_model_inst (.core_clk, .scan_request,
    .adc_neg_supply, .adc_pos_supply, .hold_diag, .diag_value,
    .full_value, .cell_volts, .diag_active, .diag_slot, .diag_valid,
    .diag_data, .meas_valid, .meas_chan, .meas_data, .scan_end_in);
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // =====
  // Shared checks and bus cycles
  task finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until ack is seen at an edge, then a idle cycle
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    @(posedge core_clk);
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge core_clk);
    rd = wb_dat_o;
    // A missing ack is a failure, never a silent pass
    if (wb_ack_o !== 1'b1)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, wb_ack_o,
               1'b1);
    end
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge core_clk);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Poll until idle with the complete flag up; a hang counts as a failure
  task wait_idle();
    int n;
    rd = 32'h1;
    for (n = 0; n < 80 && rd[1:0] !== 2'b10; n++)
      wb(1'b0, ads_pkg::OFS_STATUS, 32'h0);
    if (rd[1:0] !== 2'b10)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, rd, 32'h2);
    end
  endtask
  task run_scan(input logic [31:0] ctrl);
    wb(1'b1, ads_pkg::OFS_SCAN_CTRL, ctrl);
    wait_idle();
  endtask
  // Run a scan with one selector, then judge the result as the host would
  task diag_run(input logic [3:0] s, input logic [31:0] ctrl,
    input logic [13:0] v, input logic [13:0] lo, input logic [13:0] hi);
    wb(1'b1, ads_pkg::OFS_DIAG_CFG, {28'h0, s});
    diag_value <= v;
    run_scan(ctrl);
    wb(1'b0, ads_pkg::OFS_RES_FIRST, 32'h0);
    total_checks++;
    // Unknown bits fail the window instead of slipping through
    if ($isunknown(rd) || rd[1:0] !== 2'b00 || rd[15:2] < lo ||
        rd[15:2] > hi)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h to %h", $time,
               rd[15:2], lo, hi);
    end
  endtask
  // Steering only acts while a scan runs, so start one and look mid-cycle
  task steer(input logic [3:0] c, input logic o, input logic [19:0] m,
    input logic [19:0] e);
    wb(1'b1, ads_pkg::OFS_DIAG_CFG, {28'h0, c});
    wb(1'b1, ads_pkg::OFS_SCAN_CTRL, 32'h101 | {o, 1'b0});
    @(negedge core_clk);
    chk({12'h0, m & {adc_bipolar, adc_in_short, adc_in_ground,
      cell_ls_ground, ls_in_short, chop_disable, ref_thermistor,
      adc_neg_supply, adc_pos_supply, dac_route, dac_code}}, {12'h0, e});
    @(posedge core_clk);
    wait_idle();
  endtask
  // =====
  // Scenarios
  task t_steer();
    hold_diag <= 1'b1;
    steer(4'h6, 1'b0, 20'hfffff, 20'hc0000);
    steer(4'h6, 1'b1, 20'hfffff, 20'h94000);
    steer(4'h9, 1'b0, 20'hfffff, 20'ha2000);
    steer(4'hc, 1'b0, 20'hfffff, 20'h8c000);
    steer(4'ha, 1'b0, 20'hfffff, 20'h81000);
    steer(4'hb, 1'b0, 20'hfffff, 20'h80800);
    steer(4'h8, 1'b0, 20'h007ff, 20'h00500);
    steer(4'h7, 1'b0, 20'h007ff, 20'h006ff);
    hold_diag <= 1'b0;
  endtask
  task t_result();
    wb(1'b1, ads_pkg::OFS_CAL_OFS, 32'h4);
    diag_run(4'h6, 32'h161, 14'h2004, 14'h1ff3, 14'h200d);
    rdchk(ads_pkg::OFS_RES_FIRST, 32'h8000);
    chk({29'h0, oversample_out}, 32'h3);
    diag_run(4'h6, 32'h163, 14'h1ff0, 14'h1fea, 14'h2011);
    diag_run(4'h9, 32'h161, 14'h2004, 14'h1ff8, 14'h2003);
    diag_run(4'hc, 32'h161, 14'h1d74, 14'h1d70, 14'h228f);
    diag_run(4'h8, 32'h161, 14'h1008, 14'h0fd0, 14'h1040);
    diag_run(4'h7, 32'h161, 14'h2ffe, 14'h2f80, 14'h3070);
    diag_run(4'h9, 32'h061, 14'h2004, 14'h1fb0, 14'h204f);
    rdchk(ads_pkg::OFS_RES_FIRST, 32'h8010);
    chk({31'h0, converter_cal_enable}, 32'h0);
  endtask
  task t_stuck();
    wb(1'b1, ads_pkg::OFS_DIAG_CFG, 32'h0);
    run_scan(32'h301);
    chk(rd & 32'hf, 32'h2);
    full_value <= 14'h3ff8;
    run_scan(32'h301);
    chk(rd & 32'hf, 32'ha);
  endtask
  task t_switch();
    wb(1'b1, ads_pkg::OFS_THR_SHORT, 32'h1000);
    cell_volts[3*14 +: 14] = 14'h0800;
    run_scan(32'h111);
    rdchk(ads_pkg::OFS_ALERT, 32'h10008);
    chk({28'h0, alternate_mux_path, oversample_out}, 32'h8);
    wb(1'b1, ads_pkg::OFS_THR_LOW, 32'h800);
    wb(1'b1, ads_pkg::OFS_THR_HIGH, 32'h3000);
    wb(1'b1, ads_pkg::OFS_TOP_CELL, 32'h22);
    cell_volts[3*14 +: 14] = 14'h2000;
    cell_volts[1*14 +: 14] = 14'h0100;
    cell_volts[5*14 +: 14] = 14'h3500;
    for (int c = 5; c < 8; c++)
    begin
      run_scan(32'h101 | (c << 2));
      rdchk(ads_pkg::OFS_ALERT, 32'h10002);
    end
    wb(1'b1, ads_pkg::OFS_TOP_CELL, 32'h2d);
    run_scan(32'h115);
    rdchk(ads_pkg::OFS_ALERT, 32'h10022);
    wb(1'b1, ads_pkg::OFS_ALERT, 32'h0);
    rdchk(ads_pkg::OFS_ALERT, 32'h22);
    cell_volts = {14{14'h2000}};
    run_scan(32'h111);
    rdchk(ads_pkg::OFS_ALERT, 32'h0);
  endtask
  initial
  begin
    #500us;
    mismatches++;
    finish_test();
  end
  initial
  begin
    srst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, hold_diag} = '0;
    wb_sel_i = 4'hf;
    diag_value = 14'h2000;
    full_value = 14'h3ffc;
    cell_volts = {14{14'h2000}};
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rdchk(ads_pkg::OFS_SCAN_CTRL, 32'h100);
    rdchk(ads_pkg::OFS_THR_HIGH, 32'h3fff);
    rdchk(ads_pkg::OFS_TOP_CELL, 32'hdd);
    wb(1'b1, 8'h30, 32'h5);
    rdchk(8'h30, 32'h0);
    t_steer();
    t_result();
    t_stuck();
    t_switch();
    finish_test();
  end
endmodule
